// *** rtl/pcmo_cfg.svh ***
// Offsets, field positions, reset values and timing constants of the PCM output port
`ifndef PCMO_CFG_SVH
`define PCMO_CFG_SVH

`define PCMO_OFS_DIV 8'h54
`define PCMO_OFS_CONF 8'h55
`define PCMO_OFS_ROUTE 8'h56
`define PCMO_OFS_POST 8'h61
`define PCMO_OFS_HOLD 8'h63
`define PCMO_OFS_FRAC_L 8'h64
`define PCMO_OFS_FRAC_H 8'h65

`define PCMO_RST_DIV 8'h03
`define PCMO_RST_CONF 8'h21
`define PCMO_RST_ROUTE 2'h0
`define PCMO_RST_POST 5'h07
`define PCMO_RST_HOLD 1'h0
`define PCMO_RST_FRAC_L 8'h46
`define PCMO_RST_FRAC_H 8'h5b

`define PCMO_BIT_LSB_FIRST 6
`define PCMO_BIT_PAD_LEFT 5
`define PCMO_BIT_WS_POL 4
`define PCMO_BIT_FRAMING 3
`define PCMO_BIT_EDGE 2

`define PCMO_FRAC_ONE 17'h10000
`define PCMO_SLOT_NARROW 6'h10
`define PCMO_SLOT_WIDE 6'h20
`define PCMO_LAST_NARROW 6'h1f
`define PCMO_LAST_WIDE 6'h3f
`define PCMO_OVERSAMPLE_CLOCK_TRACK_KHZ 12288

`endif

// *** rtl/pcmo_pkg.sv ***
// Types shared by the PCM output port
package pcmo_pkg;

    typedef enum logic [1:0] {
        PCMO_ROUTE_STRAIGHT = 2'h0,
        PCMO_ROUTE_LEFT_BOTH = 2'h1,
        PCMO_ROUTE_RIGHT_BOTH = 2'h2,
        PCMO_ROUTE_SWAP = 2'h3
    } pcmo_route_e;

    typedef enum logic [1:0] {
        PCMO_WIDTH_16 = 2'h0,
        PCMO_WIDTH_18 = 2'h1,
        PCMO_WIDTH_20 = 2'h2,
        PCMO_WIDTH_24 = 2'h3
    } pcmo_width_e;

    typedef logic [23:0] pcmo_sample_t;

endpackage : pcmo_pkg

// *** rtl/pcmo_pair_buf.sv ***
// Two-entry buffer for left/right sample pairs
`timescale 1ns/1ps
`default_nettype none

module pcmo_pair_buf (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic [47:0] in_data_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    output logic [47:0] out_data_o,
    output logic out_valid_o,
    input wire logic out_ready_i
);
    logic [47:0] mem_q [2];
    logic wr_ptr_q;
    logic rd_ptr_q;
    logic [1:0] count_q;
    logic [1:0] count_d;
    logic push;
    logic pop;

    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;
    assign out_data_o = mem_q[rd_ptr_q];

    always_comb begin
        count_d = count_q;
        if (push && !pop) begin
            count_d = count_q + 2'h1;
        end else if (pop && !push) begin
            count_d = count_q - 2'h1;
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_q <= 2'h0;
            in_ready_o <= 1'b1;
            out_valid_o <= 1'b0;
        end else begin
            count_q <= count_d;
            in_ready_o <= (count_d != 2'h2);
            out_valid_o <= (count_d != 2'h0);
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_q <= 1'b0;
            rd_ptr_q <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_q <= ~wr_ptr_q;
            end
            if (pop) begin
                rd_ptr_q <= ~rd_ptr_q;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (push) begin
            mem_q[wr_ptr_q] <= in_data_i;
        end
    end

endmodule : pcmo_pair_buf

`default_nettype wire

// *** rtl/pcmo_port.sv ***
// Serial PCM output port: registers, oversampling clock, bit clock and serializer
`timescale 1ns/1ps
`include "pcmo_cfg.svh"
`default_nettype none

// Summary of operation
// - Bit clock equals oversampling clock over 2*(1+divisor); divisor resets to 0x03.
// - A word-select period spans 32 bit clocks at 16 bits, else 64.
// - Bit 6 set sends least significant bit first, clear sends most first.
// - Bit 5 picks right padding (0) or left padding (1) for wide samples.
// - Polarity bit 1 drives word select low for left; 0 inverts it.
// - Bit 3 picks standard framing (0) or alternative; reads 0 after resets.
// - Edge bit 0 changes data on falling bit-clock edge; 1 on rising.
// - Width field 00/01/10/11 gives 16/18/20/24 bits; wide uses 32 slots.
// - Configuration register resets to 0x21 on hardware and software reset.
// - Routing 00 straight, 01 left to both, 10 right to both, 11 swap.
// - Five-bit post divider divides oscillator by value plus one; resets to 0x07.
// - Core rewrites post divider for stream rate; host may write it too.
// - Hold bit set keeps oversampling clock at user setting despite rate changes.
// - Hold clear lets oversampling clock track 512, 384 or 256 times rate.
// - Tracking mode default oversampling clock is 12.288 MHz.
// - Fraction is high*256+low; clock is ref/(N+1)*(M+1+frac/65536)/(post+1).
module pcmo_port
    import pcmo_pkg::*;
#(
    parameter logic [7:0] PLL_IN_DIV = 8'h00,
    parameter logic [7:0] PLL_INT_MULT = 8'h00
) (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic soft_reset_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic [4:0] core_post_div_i,
    input wire logic core_post_div_wr_i,
    input wire logic [23:0] pcm_left_i,
    input wire logic [23:0] pcm_right_i,
    input wire logic pcm_valid_i,
    output logic pcm_ready_o,
    output logic oversample_clock_o,
    output logic bit_clock_o,
    output logic word_select_o,
    output logic serial_data_o
);
    logic [7:0] div_q;
    logic [6:0] conf_q;
    logic [1:0] route_q;
    logic [4:0] post_q;
    logic hold_q;
    logic [7:0] frac_l_q;
    logic [7:0] frac_h_q;
    logic [7:0] act_div_q;
    logic [6:0] act_conf_q;
    logic [7:0] pre_cnt_q;
    logic [23:0] acc_q;
    logic [24:0] acc_sum;
    logic [4:0] post_cnt_q;
    logic osc_tick_q;
    logic [8:0] half_cnt_q;
    logic [8:0] half_last;
    logic launch;
    logic [5:0] pos_q;
    logic [5:0] pos_last;
    logic [5:0] next_pos;
    logic [5:0] lead_pos;
    logic frame_start;
    logic [6:0] cfg_now;
    logic [47:0] buf_data;
    logic buf_valid;
    pcmo_sample_t cur_l_q;
    pcmo_sample_t cur_r_q;
    pcmo_sample_t new_l;
    pcmo_sample_t new_r;
    logic host_post_wr;

    assign host_post_wr = reg_wr_i && (reg_addr_i == `PCMO_OFS_POST);

    // Register file; both resets load the defaults
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_q <= `PCMO_RST_DIV;
            conf_q <= 7'(`PCMO_RST_CONF);
            route_q <= `PCMO_RST_ROUTE;
            post_q <= `PCMO_RST_POST;
            hold_q <= `PCMO_RST_HOLD;
            frac_l_q <= `PCMO_RST_FRAC_L;
            frac_h_q <= `PCMO_RST_FRAC_H;
        end else if (soft_reset_i) begin
            div_q <= `PCMO_RST_DIV;
            conf_q <= 7'(`PCMO_RST_CONF);
            route_q <= `PCMO_RST_ROUTE;
            post_q <= `PCMO_RST_POST;
            hold_q <= `PCMO_RST_HOLD;
            frac_l_q <= `PCMO_RST_FRAC_L;
            frac_h_q <= `PCMO_RST_FRAC_H;
        end else begin
            if (reg_wr_i) begin
                case (reg_addr_i)
                    `PCMO_OFS_DIV: div_q <= reg_wdata_i;
                    `PCMO_OFS_CONF: conf_q <= reg_wdata_i[6:0];
                    `PCMO_OFS_ROUTE: route_q <= reg_wdata_i[1:0];
                    `PCMO_OFS_HOLD: hold_q <= reg_wdata_i[0];
                    `PCMO_OFS_FRAC_L: frac_l_q <= reg_wdata_i;
                    `PCMO_OFS_FRAC_H: frac_h_q <= reg_wdata_i;
                    default: ;
                endcase
            end
            // Host write wins over a core update in the same cycle
            if (host_post_wr) begin
                post_q <= reg_wdata_i[4:0];
            end else if (core_post_div_wr_i && !hold_q) begin
                post_q <= core_post_div_i;
            end
        end
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            case (reg_addr_i)
                `PCMO_OFS_DIV: reg_rdata_o <= div_q;
                `PCMO_OFS_CONF: reg_rdata_o <= {1'b0, conf_q};
                `PCMO_OFS_ROUTE: reg_rdata_o <= {6'h00, route_q};
                `PCMO_OFS_POST: reg_rdata_o <= {3'h0, post_q};
                `PCMO_OFS_HOLD: reg_rdata_o <= {7'h00, hold_q};
                `PCMO_OFS_FRAC_L: reg_rdata_o <= frac_l_q;
                `PCMO_OFS_FRAC_H: reg_rdata_o <= frac_h_q;
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end

    // Fractional synthesizer standing in for the PLL
    assign acc_sum = {1'b0, acc_q} + {1'b0, PLL_INT_MULT + 8'h01, frac_h_q, frac_l_q};

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pre_cnt_q <= 8'h00;
            acc_q <= 24'h000000;
            post_cnt_q <= 5'h00;
            osc_tick_q <= 1'b0;
        end else begin
            osc_tick_q <= 1'b0;
            if (pre_cnt_q >= PLL_IN_DIV) begin
                pre_cnt_q <= 8'h00;
                acc_q <= acc_sum[23:0];
                if (acc_sum[24]) begin
                    if (post_cnt_q >= post_q) begin
                        post_cnt_q <= 5'h00;
                        osc_tick_q <= 1'b1;
                    end else begin
                        post_cnt_q <= post_cnt_q + 5'h01;
                    end
                end
            end else begin
                pre_cnt_q <= pre_cnt_q + 8'h01;
            end
        end
    end

    // With hold set, only the host or a hardware or software reset changes post_q, so the clock stays put
    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            oversample_clock_o <= 1'b0;
        end else if (osc_tick_q) begin
            oversample_clock_o <= ~oversample_clock_o;
        end
    end

    // Bit clock: one half period is 2*(1+divisor) oscillator edges
    assign half_last = {act_div_q, 1'b1};
    assign launch = osc_tick_q && (half_cnt_q == half_last)
        && (bit_clock_o != act_conf_q[`PCMO_BIT_EDGE]);

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            half_cnt_q <= 9'h000;
            bit_clock_o <= 1'b0;
        end else if (osc_tick_q) begin
            if (half_cnt_q == half_last) begin
                half_cnt_q <= 9'h000;
                bit_clock_o <= ~bit_clock_o;
            end else begin
                half_cnt_q <= half_cnt_q + 9'h001;
            end
        end
    end

    // Position within the frame, and the frame boundary
    assign pos_last = (act_conf_q[1:0] == PCMO_WIDTH_16) ? `PCMO_LAST_NARROW
        : `PCMO_LAST_WIDE;
    assign next_pos = (pos_q == pos_last) ? 6'h00 : pos_q + 6'h01;
    assign frame_start = launch && (next_pos == 6'h00);
    assign cfg_now = frame_start ? conf_q : act_conf_q;
    // Standard framing moves word select one bit ahead of the data
    assign lead_pos = cfg_now[`PCMO_BIT_FRAMING] ? next_pos
        : ((next_pos == pos_last) ? 6'h00 : next_pos + 6'h01);

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pos_q <= `PCMO_LAST_NARROW;
            act_div_q <= `PCMO_RST_DIV;
            act_conf_q <= 7'(`PCMO_RST_CONF);
        end else if (launch) begin
            pos_q <= next_pos;
            if (frame_start) begin
                act_div_q <= div_q;
                act_conf_q <= conf_q;
            end
        end
    end

    // Sample pair intake; an empty buffer at a frame boundary sends silence
    pcmo_pair_buf u_pair_buf (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .in_data_i({pcm_left_i, pcm_right_i}),
        .in_valid_i(pcm_valid_i),
        .in_ready_o(pcm_ready_o),
        .out_data_o(buf_data),
        .out_valid_o(buf_valid),
        .out_ready_i(frame_start)
    );

    always_comb begin
        new_l = buf_valid ? buf_data[47:24] : 24'h000000;
        new_r = buf_valid ? buf_data[23:0] : 24'h000000;
        case (pcmo_route_e'(route_q))
            PCMO_ROUTE_LEFT_BOTH: new_r = new_l;
            PCMO_ROUTE_RIGHT_BOTH: new_l = new_r;
            PCMO_ROUTE_SWAP: begin
                new_l = new_r;
                new_r = buf_valid ? buf_data[47:24] : 24'h000000;
            end
            default: ;
        endcase
    end

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cur_l_q <= 24'h000000;
            cur_r_q <= 24'h000000;
        end else if (frame_start) begin
            cur_l_q <= new_l;
            cur_r_q <= new_r;
        end
    end

    // Bit for frame position p under configuration c
    function automatic logic slot_bit(input logic [5:0] p, input logic [6:0] c,
                                      input pcmo_sample_t l, input pcmo_sample_t r);
        logic wide;
        logic [5:0] s;
        logic [5:0] w;
        logic [5:0] pin;
        logic [5:0] off;
        logic [5:0] k;
        pcmo_sample_t smp;
        wide = (c[1:0] != PCMO_WIDTH_16);
        s = wide ? `PCMO_SLOT_WIDE : `PCMO_SLOT_NARROW;
        case (pcmo_width_e'(c[1:0]))
            PCMO_WIDTH_18: w = 6'h12;
            PCMO_WIDTH_20: w = 6'h14;
            PCMO_WIDTH_24: w = 6'h18;
            default: w = 6'h10;
        endcase
        pin = wide ? {1'b0, p[4:0]} : {2'h0, p[3:0]};
        smp = (p >= s) ? r : l;
        off = c[`PCMO_BIT_PAD_LEFT] ? (s - w) : 6'h00;
        k = pin - off;
        slot_bit = 1'b0;
        if ((pin >= off) && (k < w)) begin
            if (c[`PCMO_BIT_LSB_FIRST]) begin
                slot_bit = smp[5'(6'h18 - w + k)];
            end else begin
                slot_bit = smp[5'(6'h17 - k)];
            end
        end
    endfunction : slot_bit

    always_ff @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            serial_data_o <= 1'b0;
            word_select_o <= 1'b1;
        end else if (launch) begin
            serial_data_o <= slot_bit(next_pos, cfg_now, frame_start ? new_l : cur_l_q,
                                      frame_start ? new_r : cur_r_q);
            word_select_o <= (lead_pos > pos_last[5:1]) ^ ~cfg_now[`PCMO_BIT_WS_POL];
        end
    end

    bit_toggle_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        osc_tick_q && (half_cnt_q == half_last) |=> bit_clock_o != $past(bit_clock_o))
        else $error("bit clock did not toggle at divisor count");

    frame_wrap_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        launch && (pos_q == pos_last) |=> pos_q == 6'h00)
        else $error("frame position did not wrap at frame length");

    ws_level_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        frame_start |=> word_select_o == ~act_conf_q[`PCMO_BIT_WS_POL])
        else $error("word select level wrong for channel and polarity");

    soft_reset_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        soft_reset_i |=> (conf_q == 7'h21) && (div_q == 8'h03) && (post_q == 5'h07))
        else $error("software reset did not restore defaults");

    route_swap_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        frame_start && buf_valid && (route_q == 2'h3) |=> cur_l_q == $past(buf_data[23:0]))
        else $error("swap routing did not put right sample on left");

    hold_post_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        hold_q && core_post_div_wr_i && !host_post_wr && !soft_reset_i |=> $stable(post_q))
        else $error("core changed post divider while held");

    track_post_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !hold_q && core_post_div_wr_i && !host_post_wr && !soft_reset_i
            |=> post_q == $past(core_post_div_i))
        else $error("core post divider update lost");

    shadow_cfg_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        !frame_start |=> $stable(act_conf_q) && $stable(act_div_q))
        else $error("active configuration changed mid frame");

    data_edge_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $changed(serial_data_o) |-> $past(launch)
            && ($past(bit_clock_o) != $past(act_conf_q[`PCMO_BIT_EDGE])))
        else $error("serial data changed off the launch edge");

endmodule : pcmo_port

`default_nettype wire

// *** tb/pcmo_dac_model.sv ***
// Receiving DAC model: samples the serial link and collects one slot word per channel
`timescale 1ns/1ps
`default_nettype none

module pcmo_dac_model (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic bit_clock_i,
    input wire logic word_select_i,
    input wire logic serial_data_i,
    input wire logic sample_on_fall_i,
    input wire logic aligned_i,
    input wire logic polarity_i,
    input wire logic wide_i,
    output logic [31:0] left_o,
    output logic [31:0] right_o,
    output logic [15:0] frames_o,
    output logic [15:0] glitches_o
);
    logic bck_q, sd_q, ws_q, ws_prev, chan_q, chan;
    logic [31:0] sh;
    logic [6:0] cnt;

    always @(posedge core_clk_i or posedge rst_i) begin
        if (rst_i) begin
            {bck_q, sd_q, ws_q, ws_prev, chan_q} = '0;
            sh = '0;
            cnt = '0;
            {left_o, right_o, frames_o, glitches_o} = '0;
        end else begin
            // Sampling edge is the one opposite to the launch edge
            if (bit_clock_i != bck_q && bit_clock_i != sample_on_fall_i) begin
                if (serial_data_i != sd_q || word_select_i != ws_q) glitches_o++;
                chan = (aligned_i ? word_select_i : ws_prev) ^ ~polarity_i;
                ws_prev = word_select_i;
                if (chan != chan_q) begin
                    cnt = '0;
                    sh = '0;
                end
                chan_q = chan;
                sh = {sh[30:0], serial_data_i};
                cnt++;
                if (cnt == (wide_i ? 7'd32 : 7'd16)) begin
                    if (chan) begin
                        right_o = sh;
                        frames_o++;
                    end else begin
                        left_o = sh;
                    end
                end
            end
            bck_q = bit_clock_i;
            sd_q = serial_data_i;
            ws_q = word_select_i;
        end
    end
endmodule : pcmo_dac_model

`default_nettype wire

// *** tb/testbench.sv ***
// Self-checking bench for the PCM output port
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clk = 0, rst = 1, srst = 0, wr = 0, cwr = 0, valid = 0;
    logic [7:0] addr = 0, wdata = 0, rdata, conf;
    logic [4:0] cpost = 0;
    logic [23:0] pl = 0, pr = 0;
    logic ready, oversample_clock, bclk, ws, sd, on_fall = 0, aligned = 0, pol = 0, wide = 0;
    logic [31:0] rx_l, rx_r;
    logic [15:0] frames, glitches, g0;
    logic [1:0] w, rt;
    logic [23:0] sl [3], sr [3];
    logic [7:0] ra [7] = '{8'h54, 8'h55, 8'h56, 8'h61, 8'h63, 8'h64, 8'h65};
    logic [7:0] rv [7] = '{8'h03, 8'h21, 8'h00, 8'h07, 8'h00, 8'h46, 8'h5b};
    logic [7:0] rm [7] = '{8'hff, 8'h7f, 8'h03, 8'h1f, 8'h01, 8'hff, 8'hff};
    int fails = 0, tests_run = 0, i, n;

    pcmo_port #(.PLL_IN_DIV(8'h00), .PLL_INT_MULT(8'hfe)) dut_u (
        .core_clk_i(clk), .rst_i(rst), .soft_reset_i(srst), .reg_addr_i(addr),
        .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .core_post_div_i(cpost),
        .core_post_div_wr_i(cwr), .pcm_left_i(pl), .pcm_right_i(pr), .pcm_valid_i(valid),
        .pcm_ready_o(ready), .oversample_clock_o(oversample_clock), .bit_clock_o(bclk),
        .word_select_o(ws), .serial_data_o(sd));

    pcmo_dac_model dac_u (
        .core_clk_i(clk), .rst_i(rst), .bit_clock_i(bclk), .word_select_i(ws),
        .serial_data_i(sd), .sample_on_fall_i(on_fall), .aligned_i(aligned),
        .polarity_i(pol), .wide_i(wide), .left_o(rx_l), .right_o(rx_r),
        .frames_o(frames), .glitches_o(glitches));

    initial begin
        forever #2.5 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic end_of_test();
        $display("fails=%0d tests_run=%0d", fails, tests_run);
        if (fails == 0 && tests_run > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : end_of_test

    task automatic hang();
        check(32'h0, 32'h1);
        end_of_test();
    endtask : hang

    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        tick();
        addr = a;
        wdata = d;
        wr = 1;
        tick();
        wr = 0;
    endtask : wr_reg

    task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
        tick();
        addr = a;
        tick();
        check({24'h0, rdata}, {24'h0, exp});
    endtask : rd_reg

    task automatic core_upd(input logic [4:0] v);
        cpost = v;
        cwr = 1;
        tick();
        cwr = 0;
    endtask : core_upd

    // Counts inner rises (or cycles) over one period of the outer signal
    task automatic span(input int sel, output int n);
        int k, seen;
        logic o, q, iv, iq;
        n = 0;
        seen = 0;
        q = 1'b1;
        iq = 1'b1;
        for (k = 0; k < 5000 && seen < 2; k++) begin
            tick();
            o = (sel == 0) ? bclk : (sel == 1) ? ws : oversample_clock;
            iv = (sel == 0) ? oversample_clock : bclk;
            if (seen == 1 && (sel == 2 || (iv && !iq))) n++;
            if (o && !q) seen++;
            q = o;
            iq = iv;
        end
        if (seen < 2) hang();
    endtask : span

    task automatic wait_ws(input int n, input logic lvl);
        int k;
        logic q;
        q = ws;
        for (k = 0; k < 20000 && n > 0; k++) begin
            tick();
            if (ws == lvl && q != lvl) n--;
            q = ws;
        end
        if (n > 0) hang();
    endtask : wait_ws

    task automatic wait_frame();
        int k;
        logic [15:0] f;
        f = frames;
        for (k = 0; k < 3000 && frames == f; k++) tick();
        if (frames == f) hang();
    endtask : wait_frame

    task automatic push(input logic [23:0] l, input logic [23:0] r);
        int k;
        tick();
        pl = l;
        pr = r;
        valid = 1;
        for (k = 0; k < 3000 && ready !== 1'b1; k++) tick();
        if (ready !== 1'b1) hang();
        tick();
        valid = 0;
    endtask : push

    function automatic logic [31:0] exp_slot(input logic [23:0] s, input logic [7:0] c);
        int nb;
        logic [31:0] v;
        nb = (c[1:0] == 2'h3) ? 24 : 16 + 2 * c[1:0];
        v = '0;
        for (int b = 0; b < nb; b++) v[nb - 1 - b] = c[6] ? s[24 - nb + b] : s[23 - b];
        if (!c[5] && nb > 16) v = v << (32 - nb);
        return v;
    endfunction : exp_slot

    function automatic logic [23:0] pick(input logic [1:0] r, input logic right,
                                         input logic [23:0] l, input logic [23:0] rr);
        case (r)
            2'h0: return right ? rr : l;
            2'h1: return l;
            2'h2: return rr;
            default: return right ? l : rr;
        endcase
    endfunction : pick

    initial begin
        n = $urandom(44);
        repeat (16) @(posedge clk);
        #1;
        rst = 0;
        for (i = 0; i < 7; i++) rd_reg(ra[i], rv[i]);
        for (i = 1; i < 7; i++) wr_reg(ra[i], 8'hff);
        for (i = 1; i < 7; i++) rd_reg(ra[i], rm[i]);
        wr_reg(8'h57, 8'hff);
        rd_reg(8'h57, 8'h00);
        tick();
        srst = 1;
        tick();
        srst = 0;
        for (i = 0; i < 7; i++) rd_reg(ra[i], rv[i]);
        $display("register test done");
        wr_reg(8'h64, 8'hff);
        wr_reg(8'h65, 8'hff);
        span(2, n);
        span(2, n);
        check(n, 16);
        core_upd(5'h02);
        rd_reg(8'h61, 8'h02);
        span(2, n);
        span(2, n);
        check(n, 6);
        wr_reg(8'h63, 8'h01);
        core_upd(5'h05);
        rd_reg(8'h61, 8'h02);
        span(2, n);
        check(n, 6);
        wr_reg(8'h63, 8'h00);
        tick();
        addr = 8'h61;
        wdata = 8'h03;
        wr = 1;
        core_upd(5'h09);
        wr = 0;
        rd_reg(8'h61, 8'h03);
        wr_reg(8'h61, 8'h00);
        $display("post divider test done");
        for (i = 0; i < 4; i++) begin
            wr_reg(8'h54, i[7:0]);
            wr_reg(8'h55, {6'h04, i[1:0]});
            wait_ws(2, 1'b1);
            span(0, n);
            check(n, 2 * (i + 1));
            span(1, n);
            check(n, i == 0 ? 32 : 64);
        end
        wr_reg(8'h54, 8'h00);
        $display("clock ratio test done");
        for (i = 0; i < 16; i++) begin
            w = i[1:0];
            rt = i[3:2];
            conf = {1'b0, 5'($urandom()), w};
            if (i == 0) conf[6:2] = 5'h04;
            if (i == 15) conf[6:2] = 5'h1f;
            wr_reg(8'h55, conf);
            wr_reg(8'h56, {6'h00, rt});
            on_fall = conf[2];
            aligned = conf[3];
            pol = conf[4];
            wide = (w != 2'h0);
            wait_ws(3, 1'b1);
            wait_ws(1, pol);
            g0 = glitches;
            for (n = 0; n < 3; n++) begin
                sl[n] = {1'b1, 23'($urandom())};
                sr[n] = {1'b1, 23'($urandom())};
                push(sl[n], sr[n]);
                if (n == 1) begin
                    tick();
                    check({31'h0, ready}, 32'h0);
                end
            end
            for (n = 0; n < 4 && rx_l == 0; n++) wait_frame();
            for (n = 0; n < 3; n++) begin
                if (n > 0) wait_frame();
                check(rx_l, exp_slot(pick(rt, 1'b0, sl[n], sr[n]), conf));
                check(rx_r, exp_slot(pick(rt, 1'b1, sl[n], sr[n]), conf));
            end
            wait_frame();
            check(rx_l | rx_r, 32'h0);
            check({16'h0, glitches - g0}, 32'h0);
        end
        $display("stream test done");
        end_of_test();
    end
endmodule : testbench

`default_nettype wire
